// ===== verilog/bli2c_defs.svh
// Register map, field positions, reset values and timing counts
//
// Contract
// - Both bus lines are open drain: only pulled low or released.
// - Master and slave, transmit and receive operation are all supported.
// - Incoming clock and data lines are filtered before any use.
// - Start request raised at first clock fall after a START.
// - STOP (data rising while clock high) is detected apart from data.
// - Each clock pulse is recognised and its data level captured.
// - While the bus is occupied, after each bit the clock is held low until software resumes.
// - Read-bit-done flag is set when the clock pulse completes.
// - Write-bit-done flag is set only without arbitration loss.
// - Clock-rise flag is set on every low-to-high clock transition.
// - Bus-occupied flag set by any START, cleared by any STOP.
// - Resume releases the held clock and clears rise and done flags.
// - In master mode a single-bit write generates the clock pulse.
// - Automatic clock stays high at least 4.0 us, falls within 0.3 us.
// - Automatic clock timing derives from the 50 MHz system clock period, not the crystal clock.
`ifndef BLI2C_DEFS_SVH
`define BLI2C_DEFS_SVH

// -----------------------------------------------------------------------
// Register word indices (byte address = index * 4)
// -----------------------------------------------------------------------
`define BLI_IDX_CTRL 2'h0
`define BLI_IDX_BIT 2'h1
`define BLI_IDX_INT 2'h2

// -----------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------
`define BLI_CTRL_MASTER 0
`define BLI_CTRL_SCLLOW 1
`define BLI_CTRL_OUTBIT 2
`define BLI_CTRL_RESUME 3
`define BLI_STAT_HOLD 3
`define BLI_STAT_RDONE 4
`define BLI_STAT_WDONE 5
`define BLI_STAT_RISE 6
`define BLI_STAT_BUSY 7
`define BLI_STAT_INBIT 8
`define BLI_STAT_SCL 9
`define BLI_STAT_SDA 10
`define BLI_STAT_AUTO 11
`define BLI_INT_START 0

// -----------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------
`define BLI_RST_MASTER 1'h0
`define BLI_RST_SCLLOW 1'h0
`define BLI_RST_OUTBIT 1'h1
`define BLI_RST_LINE 1'h1

// -----------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------
`define BLI_CLK_PS 20000
`define BLI_XTAL_HZ 12000000
`define BLI_HIGH_PS 4000000
`define BLI_LOW_PS 4700000
`define BLI_FILT_PS 60000
`define BLI_HIGH_CYC ((`BLI_HIGH_PS + `BLI_CLK_PS - 1) / `BLI_CLK_PS)
`define BLI_LOW_CYC ((`BLI_LOW_PS + `BLI_CLK_PS - 1) / `BLI_CLK_PS)
`define BLI_FILT_CYC ((`BLI_FILT_PS + `BLI_CLK_PS - 1) / `BLI_CLK_PS)

`endif

// ===== verilog/bli2c_pkg.sv
// Types shared by the bit-level two-wire interface
package bli2c_pkg;

    // Sticky per-bit status flags
    typedef struct packed {
        logic bus_occupied_flag;
        logic clock_rise_seen_flag;
        logic write_bit_done_flag;
        logic read_bit_done_flag;
    } bli_flags_type;

    // Filtered line levels
    typedef struct packed {
        logic scl;
        logic sda;
    } bli_lines_type;

    typedef enum logic [1:0] {
        BLI_AC_IDLE,
        BLI_AC_LOW,
        BLI_AC_RISE,
        BLI_AC_HIGH
    } bli_ac_state_type;

endpackage

// ===== verilog/bli2c_filter.sv
// Glitch filter: an output follows its input once stable for LEN cycles
`timescale 1ns/1ps
`default_nettype none
`include "bli2c_defs.svh"
module bli2c_filter
    import bli2c_pkg::*;
#(
    parameter int W = 2,
    parameter int LEN = `BLI_FILT_CYC
)
(
    input wire logic clk_i,  // System clock
    input wire logic rst_i,  // Synchronous reset
    input wire logic [W-1:0] raw_i,  // Line levels as seen on pins
    output logic [W-1:0] filt_o  // Filtered levels
);

    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            logic [7:0] cnt_q;
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    cnt_q <= 8'h00;
                    filt_o[g] <= `BLI_RST_LINE;
                end
                else if (raw_i[g] == filt_o[g])
                begin
                    cnt_q <= 8'h00;
                end
                else if (cnt_q == 8'(LEN - 1))
                begin
                    // Short spikes never reach the detectors
                    cnt_q <= 8'h00;
                    filt_o[g] <= raw_i[g];
                end
                else
                begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// ===== verilog/bli2c_autoclk.sv
// Automatic master clock pulse generator
`timescale 1ns/1ps
`default_nettype none
`include "bli2c_defs.svh"
module bli2c_autoclk
    import bli2c_pkg::*;
#(
    parameter int HIGH_CYC = `BLI_HIGH_CYC,
    parameter int LOW_CYC = `BLI_LOW_CYC
)
(
    input wire logic clk_i,  // System clock
    input wire logic rst_i,  // Synchronous reset
    input wire logic go_i,  // Start one clock pulse
    input wire logic scl_i,  // Filtered clock line
    output logic pull_low_o,  // Hold clock line low
    output logic busy_o  // Pulse in progress
);

    bli_ac_state_type state_q;
    logic [8:0] cnt_q;

    // -------------------------------------------------------------------
    // Pulse sequencer
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q <= BLI_AC_IDLE;
            cnt_q <= 9'h000;
        end
        else
        begin
            case (state_q)
                BLI_AC_IDLE:
                begin
                    cnt_q <= 9'h000;
                    if (go_i)
                    begin
                        state_q <= BLI_AC_LOW;
                    end
                end
                BLI_AC_LOW:
                begin
                    // Low phase gives data set-up before the rise
                    if (cnt_q == 9'(LOW_CYC - 1))
                    begin
                        cnt_q <= 9'h000;
                        state_q <= BLI_AC_RISE;
                    end
                    else
                    begin
                        cnt_q <= cnt_q + 9'h001;
                    end
                end
                BLI_AC_RISE:
                begin
                    // High time counts from the seen rise, so a slave
                    // stretching the clock cannot shorten it
                    if (scl_i)
                    begin
                        state_q <= BLI_AC_HIGH;
                    end
                end
                BLI_AC_HIGH:
                begin
                    if (cnt_q == 9'(HIGH_CYC - 1))
                    begin
                        cnt_q <= 9'h000;
                        state_q <= BLI_AC_IDLE;
                    end
                    else
                    begin
                        cnt_q <= cnt_q + 9'h001;
                    end
                end
                default:
                begin
                    state_q <= BLI_AC_IDLE;
                end
            endcase
        end
    end

    always_comb
    begin
        pull_low_o = go_i || (state_q == BLI_AC_LOW);
        busy_o = (state_q != BLI_AC_IDLE);
    end

endmodule
`default_nettype wire

// ===== verilog/bli2c_top.sv
// Bit-level two-wire serial interface with a Wishbone register port
//
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "bli2c_defs.svh"
module bli2c_top
    import bli2c_pkg::*;
#(
    parameter int FILT_CYC = `BLI_FILT_CYC,
    parameter int HIGH_CYC = `BLI_HIGH_CYC,
    parameter int LOW_CYC = `BLI_LOW_CYC
)
(
    input wire logic clk_i,  // System clock, 50 MHz
    input wire logic rst_i,  // Synchronous reset, active high
    input wire logic wb_cyc_i,  // Wishbone cycle
    input wire logic wb_stb_i,  // Wishbone strobe
    input wire logic wb_we_i,  // Wishbone write enable
    input wire logic [3:0] wb_adr_i,  // Wishbone byte address
    input wire logic [3:0] wb_sel_i,  // Wishbone byte selects
    input wire logic [31:0] wb_dat_i,  // Wishbone write data
    output logic [31:0] wb_dat_o,  // Wishbone read data
    output logic wb_ack_o,  // Wishbone acknowledge
    input wire logic scl_i,  // Clock line level
    output logic scl_o,  // Clock line output, always low
    output logic scl_oe_o,  // Clock line pull-down enable
    input wire logic sda_i,  // Data line level
    output logic sda_o,  // Data line output, always low
    output logic sda_oe_o,  // Data line pull-down enable
    output logic start_irq_o  // Start request to the CPU
);

    // -------------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------------
    bli_lines_type raw;
    bli_lines_type filt;
    bli_lines_type prev_q;
    bli_flags_type flags_q;
    logic master_q;
    logic scl_low_q;
    logic output_bit_value_q;
    logic received_bit_value_q;
    logic hold_q;
    logic arb_lost_q;
    logic start_seen_q;
    logic start_irq_q;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic wr_ctrl;
    logic wr_bit;
    logic wr_int;
    logic resume;
    logic auto_go;
    logic auto_low;
    logic auto_busy;
    logic auto_busy_q;
    logic arb_now;
    logic bus_req;

    // Word index from the byte address
    function automatic logic [1:0] reg_index(input logic [3:0] adr);
        reg_index = adr[3:2];
    endfunction

    // -------------------------------------------------------------------
    // Line filtering
    // -------------------------------------------------------------------
    always_comb
    begin
        raw.scl = scl_i;
        raw.sda = sda_i;
    end

    bli2c_filter #(
        .W(2),
        .LEN(FILT_CYC)
    ) u_filter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .raw_i(raw),
        .filt_o(filt)
    );

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prev_q <= '{scl: `BLI_RST_LINE, sda: `BLI_RST_LINE};
        end
        else
        begin
            prev_q <= filt;
        end
    end

    // -------------------------------------------------------------------
    // Bus condition and edge detection
    // -------------------------------------------------------------------
    always_comb
    begin
        scl_rise = filt.scl && !prev_q.scl;
        scl_fall = !filt.scl && prev_q.scl;
        // Data moving while the clock stays high marks a condition
        start_cond = prev_q.scl && filt.scl && prev_q.sda && !filt.sda;
        stop_cond = prev_q.scl && filt.scl && !prev_q.sda && filt.sda;
        // Released data seen low while the clock is high
        arb_now = filt.scl && !filt.sda && output_bit_value_q;
    end

    // -------------------------------------------------------------------
    // Register decode
    // -------------------------------------------------------------------
    always_comb
    begin
        bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
        wr_ctrl = bus_req && wb_we_i && wb_sel_i[0]
            && (reg_index(wb_adr_i) == `BLI_IDX_CTRL);
        wr_bit = bus_req && wb_we_i && wb_sel_i[0]
            && (reg_index(wb_adr_i) == `BLI_IDX_BIT);
        wr_int = bus_req && wb_we_i && wb_sel_i[0]
            && (reg_index(wb_adr_i) == `BLI_IDX_INT);
        // Either resume bit or any single-bit write moves on
        resume = (wr_ctrl && wb_dat_i[`BLI_CTRL_RESUME]) || wr_bit;
        auto_go = wr_bit && master_q;
    end

    // -------------------------------------------------------------------
    // Control register
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            master_q <= `BLI_RST_MASTER;
            scl_low_q <= `BLI_RST_SCLLOW;
        end
        else if (wr_ctrl)
        begin
            master_q <= wb_dat_i[`BLI_CTRL_MASTER];
            // Software-timed clock for masters not using auto mode
            scl_low_q <= wb_dat_i[`BLI_CTRL_SCLLOW];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            output_bit_value_q <= `BLI_RST_OUTBIT;
        end
        else if (wr_bit)
        begin
            output_bit_value_q <= wb_dat_i[0];
        end
        else if (wr_ctrl)
        begin
            // Lets a master move data with the clock high: START, STOP
            output_bit_value_q <= wb_dat_i[`BLI_CTRL_OUTBIT];
        end
    end

    // -------------------------------------------------------------------
    // Received bit
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            received_bit_value_q <= `BLI_RST_LINE;
        end
        else if (scl_rise)
        begin
            received_bit_value_q <= filt.sda;
        end
    end

    // -------------------------------------------------------------------
    // Clock stretching
    // -------------------------------------------------------------------
    // End of an automatic pulse: pull low so the bit closes with a fall
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            auto_busy_q <= 1'b0;
        end
        else
        begin
            auto_busy_q <= auto_busy;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            hold_q <= 1'b0;
        end
        else if ((scl_fall && flags_q.bus_occupied_flag)
            || (auto_busy_q && !auto_busy))
        begin
            // A fall in the resume cycle belongs to the next bit
            hold_q <= 1'b1;
        end
        else if (resume)
        begin
            hold_q <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Arbitration watch for the current bit
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            arb_lost_q <= 1'b0;
        end
        else if (arb_now)
        begin
            arb_lost_q <= 1'b1;
        end
        else if (resume)
        begin
            arb_lost_q <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Status flags; a set always wins over a clear
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flags_q.read_bit_done_flag <= 1'b0;
        end
        else if (scl_fall)
        begin
            flags_q.read_bit_done_flag <= 1'b1;
        end
        else if (resume)
        begin
            flags_q.read_bit_done_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flags_q.write_bit_done_flag <= 1'b0;
        end
        else if (scl_fall && !arb_lost_q)
        begin
            flags_q.write_bit_done_flag <= 1'b1;
        end
        else if (resume)
        begin
            flags_q.write_bit_done_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flags_q.clock_rise_seen_flag <= 1'b0;
        end
        else if (scl_rise)
        begin
            flags_q.clock_rise_seen_flag <= 1'b1;
        end
        else if (resume)
        begin
            flags_q.clock_rise_seen_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flags_q.bus_occupied_flag <= 1'b0;
        end
        else if (start_cond)
        begin
            flags_q.bus_occupied_flag <= 1'b1;
        end
        else if (stop_cond)
        begin
            flags_q.bus_occupied_flag <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Start request
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            start_seen_q <= 1'b0;
        end
        else if (start_cond)
        begin
            start_seen_q <= 1'b1;
        end
        else if (scl_fall || stop_cond)
        begin
            start_seen_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            start_irq_q <= 1'b0;
        end
        else if (start_seen_q && scl_fall)
        begin
            start_irq_q <= 1'b1;
        end
        else if (wr_int && wb_dat_i[`BLI_INT_START])
        begin
            start_irq_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            start_irq_o <= 1'b0;
        end
        else
        begin
            start_irq_o <= start_irq_q;
        end
    end

    // -------------------------------------------------------------------
    // Automatic clock
    // -------------------------------------------------------------------
    bli2c_autoclk #(
        .HIGH_CYC(HIGH_CYC),
        .LOW_CYC(LOW_CYC)
    ) u_autoclk (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .go_i(auto_go),
        .scl_i(filt.scl),
        .pull_low_o(auto_low),
        .busy_o(auto_busy)
    );

    // -------------------------------------------------------------------
    // Open-drain pin drive
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
        end
        else
        begin
            // Outputs stay low; only the enables move
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            // Registered pull: one cycle, well inside the fall limit
            scl_oe_o <= (hold_q && !resume) || scl_low_q || auto_low;
            sda_oe_o <= !output_bit_value_q;
        end
    end

    // -------------------------------------------------------------------
    // Wishbone slave: one wait state, unmapped words read zero
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= bus_req;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_dat_o <= 32'h0000_0000;
        end
        else if (bus_req && !wb_we_i)
        begin
            wb_dat_o <= 32'h0000_0000;
            case (reg_index(wb_adr_i))
                `BLI_IDX_CTRL:
                begin
                    wb_dat_o[`BLI_CTRL_MASTER] <= master_q;
                    wb_dat_o[`BLI_CTRL_SCLLOW] <= scl_low_q;
                    wb_dat_o[`BLI_CTRL_OUTBIT] <= output_bit_value_q;
                    wb_dat_o[`BLI_STAT_HOLD] <= hold_q;
                    wb_dat_o[`BLI_STAT_RDONE] <= flags_q.read_bit_done_flag;
                    wb_dat_o[`BLI_STAT_WDONE] <= flags_q.write_bit_done_flag;
                    wb_dat_o[`BLI_STAT_RISE] <= flags_q.clock_rise_seen_flag;
                    wb_dat_o[`BLI_STAT_BUSY] <= flags_q.bus_occupied_flag;
                    wb_dat_o[`BLI_STAT_INBIT] <= received_bit_value_q;
                    wb_dat_o[`BLI_STAT_SCL] <= filt.scl;
                    wb_dat_o[`BLI_STAT_SDA] <= filt.sda;
                    wb_dat_o[`BLI_STAT_AUTO] <= auto_busy;
                end
                `BLI_IDX_BIT:
                begin
                    wb_dat_o[0] <= received_bit_value_q;
                end
                `BLI_IDX_INT:
                begin
                    wb_dat_o[`BLI_INT_START] <= start_irq_q;
                end
                default:
                begin
                    wb_dat_o <= 32'h0000_0000;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ===== test/bli2c_checker.sv
// Concurrent checks on the two-wire interface top ports
`timescale 1ns/1ps
`default_nettype none
module bli2c_checker #(
    parameter int HIGH_CYC = 200
)
(
    input wire logic clk_i,  // Clock
    input wire logic rst_i,  // Reset
    input wire logic wb_cyc_i,  // Cycle
    input wire logic wb_stb_i,  // Strobe
    input wire logic wb_we_i,  // Write
    input wire logic wb_ack_o,  // Ack
    input wire logic scl_i,  // Clock line
    input wire logic scl_o,  // Clock out
    input wire logic scl_oe_o,  // Clock pull
    input wire logic sda_o,  // Data out
    input wire logic sda_oe_o,  // Data pull
    input wire logic start_irq_o  // Start request
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    int hi_q;
    // Length of the current high run of the clock line
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !scl_i)
            hi_q <= 0;
        else
            hi_q <= hi_q + 1;
    end
    sequence taken_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ack_once_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    scl_never_high_a: assert property (!scl_o)
        else $error("clock output driven high");
    sda_never_high_a: assert property (!sda_o)
        else $error("data output driven high");
    ack_answer_a: assert property (taken_s |=> wb_ack_o)
        else $error("request not answered in one cycle");
    ack_pulse_a: assert property (wb_ack_o |-> ack_once_s)
        else $error("ack longer than one cycle");
    irq_hold_a: assert property ($fell(start_irq_o) |-> $past(wb_cyc_i && wb_we_i))
        else $error("start request dropped without a write");
    irq_after_fall_a: assert property ($rose(start_irq_o) |-> !scl_i)
        else $error("start request while clock high");
    sda_cause_a: assert property ($changed(sda_oe_o) |-> $past(wb_cyc_i && wb_we_i))
        else $error("data pull changed without a write");
    auto_high_a: assert property ($rose(scl_oe_o) && $past(scl_i)
        |-> hi_q >= HIGH_CYC)
        else $error("clock high phase too short");
endmodule
bind bli2c_top bli2c_checker #(.HIGH_CYC(HIGH_CYC)) bli2c_checker_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .scl_i(scl_i), .scl_o(scl_o),
    .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .start_irq_o(start_irq_o));
`default_nettype wire

// ===== test/bli2c_partner.sv
// Other bus party with pull-ups on both lines
`timescale 1ns/1ps
`default_nettype none
module bli2c_partner (
    input wire logic clk_i,  // Clock
    input wire logic scl_oe_i,  // Device pulls clock
    input wire logic sda_oe_i,  // Device pulls data
    output logic scl_o,  // Resolved clock line
    output logic sda_o  // Resolved data line
);
    logic scl_low_q = 1'b0;
    logic sda_low_q = 1'b0;
    // Wired-and: low while any party pulls
    assign scl_o = !(scl_low_q || scl_oe_i);
    assign sda_o = !(sda_low_q || sda_oe_i);
    // Each step is held long enough to pass the input filter
    task automatic set_lines(input logic c, input logic d);
        @(posedge clk_i);
        scl_low_q <= c;
        sda_low_q <= d;
        repeat (12) @(posedge clk_i);
    endtask
    // Waits out any stretch after the timed release, then pulls the clock low at once
    task automatic pulse(input logic d);
        set_lines(1'b0, d);
        while (!scl_o) @(posedge clk_i);
        set_lines(1'b1, d);
    endtask
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for the bit-level two-wire interface
`timescale 1ns/1ps
`default_nettype none
module testbench import bli2c_pkg::*;;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, chk_q, b;
    logic [3:0] wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rdat;
    logic wb_ack_o, scl, sda, scl_oe, sda_oe, scl_o, sda_o, irq;
    logic [63:0] note_q[$];
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    bli2c_top #(.FILT_CYC(3), .HIGH_CYC(8), .LOW_CYC(8)) bli2c_top_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .start_irq_o(irq));
    bli2c_partner bli2c_partner_i (.clk_i(clk_i), .scl_oe_i(scl_oe),
        .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
    always #10 clk_i = ~clk_i;
    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp32(input logic [31:0] got, input logic [63:0] n);
        n_compared++;
        if ((got & n[31:0]) !== n[63:32])
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, n[63:32]);
        end
    endtask
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d,
                       input logic c);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, chk_q} <= {2'b11, w, c};
        {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, 4'hf, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        {wb_cyc_i, wb_stb_i, chk_q} <= 3'b000;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, m);
        note_q.push_back({e & m, m});
        bus(a, 1'b0, 32'h0, 1'b1);
    endtask
    // Result watcher and hang guard
    always @(posedge clk_i)
    begin
        if (wb_ack_o === 1'b1 && chk_q && note_q.size() > 0)
            cmp32(wb_dat_o, note_q.pop_front());
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial
    begin
        {clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, chk_q} = 6'b010000;
        {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        void'($urandom(68225));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(4'h0, 32'h704, 32'hfff);
        rd(4'h8, 32'h0, 32'h1);
        bus(4'hc, 1'b1, $urandom, 1'b0);
        rd(4'hc, 32'h0, 32'hffffffff);
        bli2c_partner_i.set_lines(1'b0, 1'b1);
        rd(4'h0, 32'h84, 32'hff);
        bli2c_partner_i.set_lines(1'b1, 1'b1);
        rd(4'h8, 32'h1, 32'h1);
        rd(4'h0, 32'h9c, 32'hff);
        for (int i = 0; i < 4; i++)
        begin
            b = 1'($urandom);
            bli2c_partner_i.set_lines(1'b1, !b);
            bus(4'h0, 1'b1, 32'hc, 1'b0);
            rd(4'h0, 32'h84 | {21'h0, b, 10'h0}, 32'h6ff);
            bli2c_partner_i.pulse(!b);
            rd(4'h0, 32'hdc | ({32{b}} & 32'h520), 32'h7ff);
        end
        rd(4'h8, 32'h1, 32'h1);
        bus(4'h8, 1'b1, 32'h1, 1'b0);
        rd(4'h8, 32'h0, 32'h1);
        bus(4'h0, 1'b1, 32'h5, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            b = (i == 2) ? 1'b1 : 1'($urandom);
            bli2c_partner_i.set_lines(1'b0, i == 2);
            bus(4'h4, 1'b1, {31'h0, b}, 1'b0);
            do bus(4'h0, 1'b0, 32'h0, 1'b0); while (rdat[4] !== 1'b1);
            rd(4'h0, 32'hd9 | {29'h0, b, 2'h0} | ({32{i != 2}} & 32'h20)
               | ({32{b && i != 2}} & 32'h500), 32'h7ff);
        end
        bus(4'h0, 1'b1, 32'h4, 1'b0);
        bli2c_partner_i.set_lines(1'b0, 1'b1);
        bus(4'h0, 1'b1, 32'hc, 1'b0);
        bli2c_partner_i.set_lines(1'b0, 1'b0);
        rd(4'h0, 32'h644, 32'hfff);
        bus(4'h0, 1'b1, 32'h6, 1'b0);
        bli2c_partner_i.set_lines(1'b0, 1'b0);
        rd(4'h0, 32'h456, 32'hfff);
        tally_and_finish();
    end
endmodule
`default_nettype wire
